// ===== rtl/bezel_pkg.sv
// constants for the touch-bezel sensor readout
package bezel_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_COLS = 11;
    localparam int unsigned NUM_ROWS = 22;
    localparam int unsigned NUM_BYTES = 8;
    // ------------------------------------------------------------
    // commands and control values
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_IMAGE = 8'h60;
    localparam logic [7:0] CMD_CLEAR_IRQ = 8'he0;
    localparam logic [7:0] EMIT_OFF_VAL = 8'h00;
    localparam logic [7:0] EMIT_ON_VAL = 8'h01;
    // ------------------------------------------------------------
    // sensor image byte layout
    // ------------------------------------------------------------
    localparam int unsigned COL_LO_BYTE = 0;
    localparam int unsigned COL_HI_BYTE = 1;
    localparam int unsigned ROW_B0_BYTE = 2;
    localparam int unsigned ROW_B1_BYTE = 3;
    localparam int unsigned ROW_B2_BYTE = 4;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic EMIT_OFF_N_RST = 1'b0;
    localparam logic [7:0] DATA_RST = 8'h00;
endpackage

// ===== rtl/bezel_sync.sv
// two-flop synchroniser for a bus of pin inputs
`timescale 1ns/10ps
`default_nettype none
module bezel_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/ir_touch_bezel_scan.sv
// touch-bezel sensor readout: emitter control, sensor image, change interrupt
`timescale 1ns/10ps
`default_nettype none
module ir_touch_bezel_scan #(
    parameter int unsigned NCOL = bezel_pkg::NUM_COLS,
    parameter int unsigned NROW = bezel_pkg::NUM_ROWS
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // host writes and reads
    input wire logic cmd_wr_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic data_rd_in,
    input wire logic emit_wr_in,
    input wire logic [7:0] emit_data_in,
    output logic [7:0] data_out,
    output logic data_valid_out,
    // sensors and emitters
    input wire logic [NCOL-1:0] col_beam_seen_in,
    input wire logic [NROW-1:0] row_beam_seen_in,
    output logic emitter_off_n_out,
    // interrupt
    output logic irq_out
);
    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [NCOL-1:0] col_seen_s;
    logic [NROW-1:0] row_seen_s;
    bezel_sync #(.WIDTH(NCOL)) u_col_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .async_in(col_beam_seen_in),
        .sync_out(col_seen_s)
    );
    bezel_sync #(.WIDTH(NROW)) u_row_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .async_in(row_beam_seen_in),
        .sync_out(row_seen_s)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        IDLE,
        READING
    } rd_e;

    typedef struct packed {
        rd_e rd_state;
        logic [2:0] byte_idx;
        logic [NCOL-1:0] col_miss;
        logic [NROW-1:0] row_miss;
        logic primed;
        logic irq;
        logic emit_off_n;
        logic [7:0] data;
        logic valid;
    } state_s;

    state_s st_q;
    state_s st_d;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // strobe qualified by an exact code
    function automatic logic code_hit(input logic wr, input logic [7:0] data, input logic [7:0] code);
        code_hit = wr && (data == code);
    endfunction

    // image word, columns from byte 0, rows from byte 2
    function automatic logic [63:0] image_word(input logic [NCOL-1:0] c, input logic [NROW-1:0] r);
        logic [63:0] img;
        img = '0;
        img[bezel_pkg::COL_LO_BYTE*8 +: NCOL] = c;
        img[bezel_pkg::ROW_B0_BYTE*8 +: NROW] = r;
        image_word = img;
    endfunction

    // byte select by read index
    function automatic logic [7:0] image_byte(input logic [63:0] img, input logic [2:0] idx);
        if (idx == 3'h0) begin
            image_byte = img[7:0];
        end else if (idx == 3'h1) begin
            image_byte = img[15:8];
        end else if (idx == 3'h2) begin
            image_byte = img[23:16];
        end else if (idx == 3'h3) begin
            image_byte = img[31:24];
        end else if (idx == 3'h4) begin
            image_byte = img[39:32];
        end else if (idx == 3'h5) begin
            image_byte = img[47:40];
        end else if (idx == 3'h6) begin
            image_byte = img[55:48];
        end else begin
            image_byte = img[63:56];
        end
    endfunction

    // any receptor changed since the last snapshot
    function automatic logic snap_change(input logic [NCOL-1:0] cn, input logic [NROW-1:0] rn,
                                         input logic [NCOL-1:0] co, input logic [NROW-1:0] ro);
        snap_change = (cn != co) || (rn != ro);
    endfunction

    // ------------------------------------------------------------
    // decoded strobes
    // ------------------------------------------------------------
    logic read_cmd;
    logic clear_cmd;
    logic emit_off_req;
    logic emit_on_req;
    logic last_byte;
    logic sensors_moved;
    logic [63:0] image_now;

    assign read_cmd = code_hit(cmd_wr_in, cmd_data_in, bezel_pkg::CMD_READ_IMAGE);
    assign clear_cmd = code_hit(cmd_wr_in, cmd_data_in, bezel_pkg::CMD_CLEAR_IRQ);
    assign emit_off_req = code_hit(emit_wr_in, emit_data_in, bezel_pkg::EMIT_OFF_VAL);
    assign emit_on_req = code_hit(emit_wr_in, emit_data_in, bezel_pkg::EMIT_ON_VAL);
    assign last_byte = (st_q.byte_idx == 3'h7);
    assign sensors_moved = snap_change(~col_seen_s, ~row_seen_s, st_q.col_miss, st_q.row_miss);
    assign image_now = image_word(st_q.col_miss, st_q.row_miss);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.valid = 1'b0;

        // --------------------------------------------------------
        // sensor snapshot
        // --------------------------------------------------------
        st_d.col_miss = ~col_seen_s;
        st_d.row_miss = ~row_seen_s;
        st_d.primed = 1'b1;

        // --------------------------------------------------------
        // emitter control
        // --------------------------------------------------------
        if (emit_off_req) begin
            st_d.emit_off_n = 1'b0;
        end else if (emit_on_req) begin
            st_d.emit_off_n = 1'b1;
        end

        // --------------------------------------------------------
        // read sequence
        // --------------------------------------------------------
        if (data_rd_in) begin
            st_d.valid = 1'b1;
            if (st_q.rd_state == READING) begin
                st_d.data = image_byte(image_now, st_q.byte_idx);
                st_d.byte_idx = st_q.byte_idx + 3'h1;
                if (last_byte) begin
                    st_d.rd_state = IDLE;
                end
            end else begin
                st_d.data = bezel_pkg::DATA_RST;
            end
        end
        // a new read command restarts at byte 0
        if (read_cmd) begin
            st_d.rd_state = READING;
            st_d.byte_idx = 3'h0;
        end

        // --------------------------------------------------------
        // interrupt, a change beats a clear
        // --------------------------------------------------------
        if (clear_cmd) begin
            st_d.irq = 1'b0;
        end
        if (st_q.primed && sensors_moved) begin
            st_d.irq = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '{
                rd_state: IDLE,
                byte_idx: 3'h0,
                col_miss: '0,
                row_miss: '0,
                primed: 1'b0,
                irq: 1'b0,
                emit_off_n: bezel_pkg::EMIT_OFF_N_RST,
                data: bezel_pkg::DATA_RST,
                valid: 1'b0
            };
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign data_out = st_q.data;
    assign data_valid_out = st_q.valid;
    assign emitter_off_n_out = st_q.emit_off_n;
    assign irq_out = st_q.irq;
endmodule
`default_nettype wire

// ===== testbench/bezel_chk_sva.sv
// checker for the bezel readout
`timescale 1ns/10ps
`default_nettype none
module bezel_chk(input wire logic mclk_in, input wire logic rst_n_in, input wire logic cmd_wr_in,
    input wire logic [7:0] cmd_data_in, input wire logic data_rd_in, input wire logic emit_wr_in,
    input wire logic [7:0] emit_data_in, input wire logic [7:0] data_out, input wire logic data_valid_out,
    input wire logic emitter_off_n_out, input wire logic irq_out, input wire logic [10:0] col_beam_seen_in,
    input wire logic [21:0] row_beam_seen_in);
default clocking @(posedge mclk_in); endclocking
default disable iff (!rst_n_in);
sequence s_clr; cmd_wr_in && cmd_data_in == 8'he0; endsequence
property p_off; emit_wr_in && emit_data_in == 8'h00 |=> !emitter_off_n_out; endproperty
property p_on; emit_wr_in && emit_data_in == 8'h01 |=> emitter_off_n_out; endproperty
property p_eh; !emit_wr_in || emit_data_in > 8'h01 |=> $stable(emitter_off_n_out); endproperty
property p_vld; data_rd_in |=> data_valid_out; endproperty
property p_vp; !data_rd_in |=> !data_valid_out; endproperty
property p_dh; !data_rd_in |=> $stable(data_out); endproperty
property p_ih; irq_out && !cmd_wr_in |=> irq_out; endproperty
property p_ir; s_clr and $past(col_beam_seen_in, 2) == $past(col_beam_seen_in, 3)
    and $past(row_beam_seen_in, 2) == $past(row_beam_seen_in, 3) |=> !irq_out; endproperty
a_off: assert property (p_off) else $error("emitters not off");
a_on: assert property (p_on) else $error("emitters not on");
a_eh: assert property (p_eh) else $error("emitter line moved");
a_vld: assert property (p_vld) else $error("no read answer");
a_vp: assert property (p_vp) else $error("stray valid");
a_dh: assert property (p_dh) else $error("data moved");
a_ih: assert property (p_ih) else $error("irq lost");
a_ir: assert property (p_ir) else $error("irq after clear");
endmodule
bind ir_touch_bezel_scan bezel_chk bezel_chk_inst(.mclk_in, .rst_n_in, .cmd_wr_in, .cmd_data_in,
    .data_rd_in, .emit_wr_in, .emit_data_in, .data_out, .data_valid_out, .emitter_off_n_out, .irq_out,
    .col_beam_seen_in, .row_beam_seen_in);
`default_nettype wire

// ===== testbench/bezel_sensors.sv
// receptor model: beams seen only while emitters are lit
`timescale 1ns/10ps
`default_nettype none
module bezel_sensors(input wire logic on_in, input wire logic [32:0] miss_in,
    output logic [10:0] col_out, output logic [21:0] row_out);
assign {row_out, col_out} = on_in ? ~miss_in : 33'h0;
endmodule
`default_nettype wire

// ===== testbench/test_ir_touch_bezel_scan.sv
// self-checking bench for the bezel readout
`timescale 1ns/10ps
`default_nettype none
module test_ir_touch_bezel_scan;
logic mclk_in = 0, rst_n_in = 0, cmd_wr_in = 0, data_rd_in = 0, emit_wr_in = 0;
logic data_valid_out, emitter_off_n_out, irq_out;
logic [7:0] cmd_data_in = 0, emit_data_in = 0, data_out;
logic [10:0] col;
logic [21:0] row;
logic [32:0] miss = 0;
int num_errors = 0, tests_run = 0, seed = 38049, n;
always #20 mclk_in = ~mclk_in;
bezel_sensors bezel_sensors_inst(.on_in(emitter_off_n_out), .miss_in(miss), .col_out(col), .row_out(row));
ir_touch_bezel_scan ir_touch_bezel_scan_inst(.mclk_in, .rst_n_in, .cmd_wr_in, .cmd_data_in, .data_rd_in,
    .emit_wr_in, .emit_data_in, .data_out, .data_valid_out, .col_beam_seen_in(col),
    .row_beam_seen_in(row), .emitter_off_n_out, .irq_out);
function automatic logic [63:0] img(logic [32:0] m);
    return {26'h0, m[32:11], 5'h0, m[10:0]};
endfunction
task automatic complete_run;
    $display("errors %0d tests %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
task automatic chk(logic [7:0] g, logic [7:0] e);
    tests_run++;
    if (g !== e) begin
        num_errors++;
        $display("Error %0t: got %h want %h", $time, g, e);
    end
endtask
task automatic tick; @(posedge mclk_in); #1; endtask
task automatic emit(logic [7:0] v, logic e);
    emit_data_in = v; emit_wr_in = 1; tick; emit_wr_in = 0;
    chk({7'h0, emitter_off_n_out}, {7'h0, e});
endtask
task automatic cmd(logic [7:0] v); cmd_data_in = v; cmd_wr_in = 1; tick; cmd_wr_in = 0; endtask
task automatic settle;
    n = 0;
    do begin repeat (8) tick; cmd(8'he0); tick; n++; end while (irq_out !== 1'b0 && n < 20);
    if (irq_out !== 1'b0) begin num_errors++; complete_run; end
endtask
task automatic readimg(logic [63:0] e);
    cmd(8'h60);
    data_rd_in = 1;
    for (int k = 0; k < 9; k++) begin
        tick;
        chk({7'h0, data_valid_out}, 8'h01);
        chk(data_out, k < 8 ? e[8*k+:8] : 8'h00);
    end
    data_rd_in = 0;
endtask
initial begin
    repeat (4) tick;
    rst_n_in = 1;
    tick;
    emit(8'h00, 0);
    settle;
    readimg(img('1));
    for (int i = 0; i < 4; i++) begin
        miss = i == 0 ? 33'h100000400 : 33'({$random(seed), $random(seed)});
        emit(8'h01, 1);
        emit(8'h07, 1);
        repeat (4) tick;
        chk({7'h0, irq_out}, 8'h01);
        settle;
        readimg(img(miss));
    end
    emit(8'h00, 0);
    emit(8'h02, 0);
    complete_run;
end
endmodule
`default_nettype wire
